// ==== include/usf_consts.vh ====
`ifndef USF_CONSTS_VH
`define USF_CONSTS_VH

// Register byte offsets
`define USF_OFS_CONFIG 8'h50
`define USF_OFS_RESUME1 8'h54
`define USF_OFS_RESUME2 8'h58
`define USF_OFS_PAUSE1 8'h5C
`define USF_OFS_PAUSE2 8'h60
`define USF_OFS_IRQ_STATUS 8'h64
`define USF_OFS_IRQ_ENABLE 8'h68
`define USF_OFS_IRQ_CLEAR 8'h6C
`define USF_OFS_IRQ_MASKED 8'h70

// Configuration fields
`define USF_CFG_EN 0
`define USF_CFG_RXM_HI 2
`define USF_CFG_RXM_LO 1
`define USF_CFG_TXM_HI 4
`define USF_CFG_TXM_LO 3
`define USF_CFG_ANY 5
`define USF_CFG_SPEC 6
`define USF_CFG_W 7

// Flow mode encodings
`define USF_MODE_OFF 2'h0
`define USF_MODE_SET1 2'h1
`define USF_MODE_SET2 2'h2
`define USF_MODE_BOTH 2'h3

// Interrupt status bits
`define USF_IRQ_RESUME 0
`define USF_IRQ_SPECIAL 1
`define USF_IRQ_PAUSE 11
`define USF_IRQ_W 12

// Reset values
`define USF_RST_CFG 7'h00
`define USF_RST_CHAR 8'h00
`define USF_RST_IRQ 12'h000
`define USF_ZERO32 32'h00000000

`endif

// ==== hdl/usf_char_match.v ====
// Compare one received character against one programmed value
module usf_char_match (
  input wire [7:0] rx_char,
  input wire [7:0] ref_char,
  input wire enable,
  output wire hit
);

  assign hit = enable & (rx_char == ref_char);

endmodule

// ==== hdl/usf_soft_flow.v ====
// Overview of operation
// [RULE1] Feature works only while global enable bit 0 of configuration is one; special-character detection here runs on bit 6 alone.
// [RULE2] Receive mode bits 2:1 pick off, set one, set two, or both sets.
// [RULE3] Transmit mode bits 4:3 pick off, set one, set two, or both sets.
// [RULE4] Resume-on-any bit 5 lets every received character count as resume; here a received pause character pauses instead.
// [RULE5] Special-character detection runs only while bit 6 is set.
// [RULE6] First resume character is 8 bits at offset 0x54.
// [RULE7] Second resume character is 8 bits at offset 0x58.
// [RULE8] First pause character is 8 bits at offset 0x5C.
// [RULE9] Second pause character is 8 bits at offset 0x60.
// [RULE10] All configuration and character registers read zero after reset.
// [RULE11] Valid pause sets status bit 11; masked view and write-one clear.
// [RULE12] Transmit flow active: pause stops new characters, valid resume restarts.
// [RULE13] Remote stops sending after our pause, restarts after our resume.
`include "usf_consts.vh"

module usf_soft_flow (
  input wire clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire rx_valid,
  input wire [7:0] rx_data,
  output reg rx_out_valid,
  output reg [7:0] rx_out_data,
  input wire rx_fill_high,
  input wire rx_fill_low,
  output reg send_req,
  output reg [7:0] send_char,
  input wire send_ack,
  output reg tx_hold,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [`USF_CFG_W-1:0] cfg_q;
  reg [7:0] resume1_q;
  reg [7:0] resume2_q;
  reg [7:0] pause1_q;
  reg [7:0] pause2_q;
  reg [`USF_IRQ_W:0] irq_stat_q;
  reg [`USF_IRQ_W:0] irq_en_q;
  reg paused_q;
  reg remote_paused_q;
  reg [1:0] send_st_q;

  wire glob_en = cfg_q[`USF_CFG_EN];
  wire [1:0] rx_mode = cfg_q[`USF_CFG_RXM_HI:`USF_CFG_RXM_LO];
  wire [1:0] tx_mode = cfg_q[`USF_CFG_TXM_HI:`USF_CFG_TXM_LO];
  wire any_resume = cfg_q[`USF_CFG_ANY];
  wire spec_en = cfg_q[`USF_CFG_SPEC];

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then a single low cycle

  wire req = avs_read | avs_write;
  wire accept = req & ~avs_waitrequest;
  wire do_write = avs_write & ~avs_waitrequest;
  wire be0 = avs_byteenable[0];
  wire be1 = avs_byteenable[1];

  wire [`USF_IRQ_W:0] irq_masked = irq_stat_q & irq_en_q;

  reg [31:0] rdata_d;
  always @* begin
    rdata_d = `USF_ZERO32;
    case (avs_address)
      `USF_OFS_CONFIG: rdata_d[`USF_CFG_W-1:0] = cfg_q;
      `USF_OFS_RESUME1: rdata_d[7:0] = resume1_q; // see [RULE6]
      `USF_OFS_RESUME2: rdata_d[7:0] = resume2_q; // see [RULE7]
      `USF_OFS_PAUSE1: rdata_d[7:0] = pause1_q; // see [RULE8]
      `USF_OFS_PAUSE2: rdata_d[7:0] = pause2_q; // see [RULE9]
      `USF_OFS_IRQ_STATUS: rdata_d[`USF_IRQ_W:0] = irq_stat_q;
      `USF_OFS_IRQ_ENABLE: rdata_d[`USF_IRQ_W:0] = irq_en_q;
      `USF_OFS_IRQ_MASKED: rdata_d[`USF_IRQ_W:0] = irq_masked; // see [RULE11]
      default: rdata_d = `USF_ZERO32;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `USF_ZERO32;
    end else begin
      // Low for exactly one cycle per request, so a held request is not doubled
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= rdata_d;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= `USF_RST_CFG; // see [RULE10]
      resume1_q <= `USF_RST_CHAR; // see [RULE10]
      resume2_q <= `USF_RST_CHAR;
      pause1_q <= `USF_RST_CHAR;
      pause2_q <= `USF_RST_CHAR;
      irq_en_q <= {(`USF_IRQ_W+1){1'b0}};
    end else if (do_write) begin
      case (avs_address)
        `USF_OFS_CONFIG: begin
          if (be0) begin
            cfg_q <= avs_writedata[`USF_CFG_W-1:0];
          end
        end
        `USF_OFS_RESUME1: begin
          if (be0) begin
            resume1_q <= avs_writedata[7:0]; // see [RULE6]
          end
        end
        `USF_OFS_RESUME2: begin
          if (be0) begin
            resume2_q <= avs_writedata[7:0]; // see [RULE7]
          end
        end
        `USF_OFS_PAUSE1: begin
          if (be0) begin
            pause1_q <= avs_writedata[7:0]; // see [RULE8]
          end
        end
        `USF_OFS_PAUSE2: begin
          if (be0) begin
            pause2_q <= avs_writedata[7:0]; // see [RULE9]
          end
        end
        `USF_OFS_IRQ_ENABLE: begin
          if (be0) begin
            irq_en_q[7:0] <= avs_writedata[7:0];
          end
          if (be1) begin
            irq_en_q[`USF_IRQ_W:8] <= avs_writedata[`USF_IRQ_W:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received character classification

  wire tx_fc_on = glob_en & (tx_mode != `USF_MODE_OFF); // see [RULE1]
  wire use1 = (tx_mode == `USF_MODE_SET1) | (tx_mode == `USF_MODE_BOTH); // see [RULE3]
  wire use2 = (tx_mode == `USF_MODE_SET2) | (tx_mode == `USF_MODE_BOTH); // see [RULE3]

  wire hit_p1;
  wire hit_p2;
  wire hit_r1;
  wire hit_r2;
  wire hit_spec;

  usf_char_match u_pause1 (
    .rx_char(rx_data),
    .ref_char(pause1_q),
    .enable(tx_fc_on & use1),
    .hit(hit_p1)
  );

  usf_char_match u_pause2 (
    .rx_char(rx_data),
    .ref_char(pause2_q),
    .enable(tx_fc_on & use2),
    .hit(hit_p2)
  );

  usf_char_match u_resume1 (
    .rx_char(rx_data),
    .ref_char(resume1_q),
    .enable(tx_fc_on & use1),
    .hit(hit_r1)
  );

  usf_char_match u_resume2 (
    .rx_char(rx_data),
    .ref_char(resume2_q),
    .enable(tx_fc_on & use2),
    .hit(hit_r2)
  );

  // Special character is the second pause value, watched without flow control
  usf_char_match u_special (
    .rx_char(rx_data),
    .ref_char(pause2_q),
    .enable(spec_en), // see [RULE5]
    .hit(hit_spec)
  );

  wire is_pause = rx_valid & (hit_p1 | hit_p2);
  // Pause outranks resume-on-any, else a pause char would also resume
  wire is_resume = rx_valid & ~is_pause & (hit_r1 | hit_r2 | (tx_fc_on & any_resume)); // see [RULE4]
  wire is_flow_char = rx_valid & (hit_p1 | hit_p2 | hit_r1 | hit_r2);
  wire is_special = rx_valid & hit_spec;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit gating and receive forwarding

  always @(posedge clk) begin
    if (!rst_n) begin
      paused_q <= 1'b0;
      tx_hold <= 1'b0;
      rx_out_valid <= 1'b0;
      rx_out_data <= `USF_RST_CHAR;
    end else begin
      if (!tx_fc_on) begin
        paused_q <= 1'b0;
      end else if (is_pause) begin
        paused_q <= 1'b1; // see [RULE12]
      end else if (is_resume) begin
        paused_q <= 1'b0; // see [RULE12]
      end
      tx_hold <= tx_fc_on & (is_pause | (paused_q & ~is_resume)); // see [RULE12]
      // Flow characters are consumed, not passed to the receive data path
      rx_out_valid <= rx_valid & ~is_flow_char;
      if (rx_valid) begin
        rx_out_data <= rx_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive flow control: ask the transmitter to send pause or resume

  localparam ST_IDLE = 2'h0;
  localparam ST_SEND1 = 2'h1;
  localparam ST_SEND2 = 2'h2;

  wire rx_fc_on = glob_en & (rx_mode != `USF_MODE_OFF); // see [RULE1]
  wire rx_use1 = (rx_mode == `USF_MODE_SET1) | (rx_mode == `USF_MODE_BOTH); // see [RULE2]
  wire rx_both = (rx_mode == `USF_MODE_BOTH); // see [RULE2]

  wire want_pause = rx_fc_on & ~remote_paused_q & rx_fill_high;
  wire want_resume = rx_fc_on & remote_paused_q & rx_fill_low;

  // The remote is relied on to stop after our pause and wait for our resume
  always @(posedge clk) begin
    if (!rst_n) begin
      send_st_q <= ST_IDLE;
      remote_paused_q <= 1'b0;
      send_req <= 1'b0;
      send_char <= `USF_RST_CHAR;
    end else begin
      case (send_st_q)
        ST_IDLE: begin
          if (!rx_fc_on) begin
            remote_paused_q <= 1'b0;
          end else if (want_pause | want_resume) begin
            remote_paused_q <= want_pause; // see [RULE13]
            send_req <= 1'b1;
            if (rx_use1) begin
              send_char <= want_pause ? pause1_q : resume1_q;
              send_st_q <= ST_SEND1;
            end else begin
              send_char <= want_pause ? pause2_q : resume2_q;
              send_st_q <= ST_SEND2;
            end
          end
        end
        ST_SEND1: begin
          if (send_ack) begin
            if (rx_both) begin
              send_char <= remote_paused_q ? pause2_q : resume2_q; // see [RULE2]
              send_st_q <= ST_SEND2;
            end else begin
              send_req <= 1'b0;
              send_st_q <= ST_IDLE;
            end
          end
        end
        ST_SEND2: begin
          if (send_ack) begin
            send_req <= 1'b0;
            send_st_q <= ST_IDLE;
          end
        end
        default: begin
          send_req <= 1'b0;
          send_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: hardware set beats a write-one clear in the same cycle

  wire clr_hit = do_write & (avs_address == `USF_OFS_IRQ_CLEAR);
  wire [`USF_IRQ_W:0] clr_mask = clr_hit ?
      {avs_writedata[`USF_IRQ_W:8] & {(`USF_IRQ_W-7){be1}}, avs_writedata[7:0] & {8{be0}}} :
      {(`USF_IRQ_W+1){1'b0}};
  reg [`USF_IRQ_W:0] set_mask;

  always @* begin
    set_mask = {(`USF_IRQ_W+1){1'b0}};
    set_mask[`USF_IRQ_PAUSE] = is_pause; // see [RULE11]
    set_mask[`USF_IRQ_RESUME] = is_resume & paused_q;
    set_mask[`USF_IRQ_SPECIAL] = is_special; // see [RULE5]
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_q <= {(`USF_IRQ_W+1){1'b0}};
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_mask) | set_mask; // see [RULE11]
      irq <= |(((irq_stat_q & ~clr_mask) | set_mask) & irq_en_q);
    end
  end

endmodule

// ==== tb/usf_remote.sv ====
module usf_remote (
  input wire clk,
  input wire rst_n,
  input wire send_req,
  input wire [7:0] send_char,
  input wire [7:0] p1,
  input wire [7:0] p2,
  input wire slow,
  output logic send_ack,
  output logic paused
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt;
  always @(posedge clk) begin
    if (!rst_n) begin
      send_ack <= 1'b0;
      paused <= 1'b0;
      cnt <= 3'h0;
    end else begin
      // Slow mode stretches the take to exercise a long held request
      send_ack <= send_req && !send_ack && cnt >= (slow ? 3'h4 : 3'h1);
      cnt <= (send_req && !send_ack) ? cnt + 3'h1 : 3'h0;
      if (send_ack) begin
        paused <= send_char == p1 || send_char == p2;
      end
    end
  end
endmodule

// ==== tb/usf_soft_flow_sva.sv ====
module usf_soft_flow_sva (
  input wire clk,
  input wire rst_n,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_out_valid,
  input wire [7:0] rx_out_data,
  input wire rx_fill_high,
  input wire rx_fill_low,
  input wire send_req,
  input wire [7:0] send_char,
  input wire send_ack,
  input wire tx_hold,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wr_ok = avs_write && !avs_waitrequest;
  wait_one_cycle_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  upper_zero_a: assert property (!avs_waitrequest
    |-> avs_readdata[31:13] == 19'h0) else $error("reserved read bits set");
  hold_cause_a: assert property ($rose(tx_hold) |-> $past(rx_valid))
    else $error("hold without char");
  hold_release_a: assert property ($fell(tx_hold)
    |-> $past(rx_valid) || $past(wr_ok)) else $error("hold dropped without cause");
  irq_cause_a: assert property ($rose(irq) |-> $past(rx_valid) || $past(wr_ok))
    else $error("irq without cause");
  fwd_copy_a: assert property (rx_out_valid
    |-> $past(rx_valid) && rx_out_data == $past(rx_data)) else $error("forwarded char wrong");
  send_hold_a: assert property (send_req && !send_ack
    |=> send_req && $stable(send_char)) else $error("send request dropped");
  send_cause_a: assert property ($rose(send_req)
    |-> $past(rx_fill_high) || $past(rx_fill_low)) else $error("send without fill level");
  cover property ($rose(tx_hold));
  cover property ($rose(irq));
  cover property (send_ack && send_req ##1 send_req);
endmodule
bind usf_soft_flow usf_soft_flow_sva chk (.clk, .rst_n, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .rx_valid, .rx_data, .rx_out_valid, .rx_out_data, .rx_fill_high,
  .rx_fill_low, .send_req, .send_char, .send_ack, .tx_hold, .irq);

// ==== tb/usf_soft_flow_test.sv ====
`include "usf_consts.vh"
module usf_soft_flow_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [7:0] P1 = 8'h13, P2 = 8'h93, R1 = 8'h11, R2 = 8'h91;
  logic clk, rst_n, avs_read, avs_write, rx_valid, rx_fill_high, rx_fill_low;
  logic [7:0] avs_address, rx_data;
  logic [31:0] avs_writedata, q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, rx_out_valid, send_req, send_ack, tx_hold, irq, paused;
  wire [7:0] rx_out_data, send_char;
  logic [7:0] sent[$];
  logic [3:0] be = 4'hF;
  logic [8:0] fwd;
  logic [7:0] rc;
  integer seed = 19, error_cnt = 0, checks_done = 0, m = 0, e, s, h, i;
  usf_soft_flow dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(be), .avs_readdata, .avs_waitrequest, .rx_valid, .rx_data,
    .rx_out_valid, .rx_out_data, .rx_fill_high, .rx_fill_low, .send_req, .send_char,
    .send_ack, .tx_hold, .irq);
  usf_remote rm (.clk, .rst_n, .send_req, .send_char, .p1(P1), .p2(P2), .slow(m[1]),
    .send_ack, .paused);
  always @(posedge clk) if (send_ack && send_req) sent.push_back(send_char);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input [31:0] x, input [31:0] y);
    checks_done++;
    if (y !== x) begin
      error_cnt++;
      $display("MISMATCH %0s expected %h seen %h", nm, x, y);
    end
  endtask
  task bus(input bit w, input [7:0] a, input [31:0] d);
    integer n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) begin
      chk("bus timeout", 0, 1);
      print_verdict;
    end
    @(posedge clk);
  endtask
  task rxc(input [7:0] c);
    rx_valid <= 1'b1;
    rx_data <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
    @(posedge clk);
    // Forwarded char stands one cycle only, so take it here
    fwd = {rx_out_valid, rx_out_data};
  endtask
  // Waits for the chars of the current receive mode, order set one then set two
  task snd(input [7:0] a, input [7:0] b);
    integer k, n;
    k = m[0] + m[1];
    n = 0;
    while (n < 60 && (k == 0 || sent.size() < k)) begin
      @(negedge clk);
      n++;
    end
    if (sent.size() < k) begin
      chk("send timeout", 0, 1);
      print_verdict;
    end
    @(posedge clk);
    chk("send count", k, sent.size());
    if (m[0]) chk("send first", a, sent[0]);
    if (m[1]) chk("send second", b, sent[m[0]]);
    sent.delete();
  endtask
  initial begin
    {rst_n, avs_read, avs_write, rx_valid, rx_fill_high, rx_fill_low} = 6'h00;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    rx_data = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 8'h50; i <= 8'h74; i += 4) begin
      bus(0, i, 0);
      chk("reset read", 0, q);
    end
    for (i = 0; i < 4; i++) begin
      s = $random(seed);
      bus(1, 8'h54 + 4 * i, s);
      bus(0, 8'h54 + 4 * i, 0);
      chk("char reg", s & 32'hFF, q);
    end
    be <= 4'h0;
    bus(1, `USF_OFS_PAUSE2, ~s);
    be <= 4'hF;
    bus(0, `USF_OFS_PAUSE2, 0);
    chk("lane off", s & 32'hFF, q);
    bus(1, `USF_OFS_CONFIG, 32'hFFFFFFFF);
    bus(0, `USF_OFS_CONFIG, 0);
    chk("cfg reg", 32'h7F, q);
    bus(1, `USF_OFS_RESUME1, R1);
    bus(1, `USF_OFS_RESUME2, R2);
    bus(1, `USF_OFS_PAUSE1, P1);
    bus(1, `USF_OFS_PAUSE2, P2);
    bus(1, `USF_OFS_IRQ_ENABLE, 32'h802);
    $display("registers done");
    for (m = 0; m < 4; m++) for (e = 0; e < 2; e++) for (s = 0; s < 2; s++) begin
      bus(1, `USF_OFS_CONFIG, e | m << 3);
      h = e && m[s];
      rxc(s ? P2 : P1);
      chk("hold", h, tx_hold);
      chk("irq", h, irq);
      chk("fwd pause", !h, fwd[8]);
      bus(0, `USF_OFS_IRQ_STATUS, 0);
      chk("status", h << 11, q);
      rc = $random(seed) & 8'hEF;
      rxc(rc);
      chk("hold other", h, tx_hold);
      chk("fwd data", {1'b1, rc}, fwd);
      rxc(s ? R2 : R1);
      chk("hold resume", 0, tx_hold);
      chk("fwd resume", !h, fwd[8]);
      bus(0, `USF_OFS_IRQ_STATUS, 0);
      chk("status resume", h << 11 | h, q);
      bus(1, `USF_OFS_IRQ_CLEAR, 32'hFFF);
      bus(0, `USF_OFS_IRQ_MASKED, 0);
      chk("cleared", 0, q | irq);
    end
    bus(1, `USF_OFS_CONFIG, 32'h29);
    rxc(P1);
    chk("any hold", 1, tx_hold);
    rxc($random(seed) & 8'hEF);
    chk("any resume", 0, tx_hold);
    for (s = 0; s < 2; s++) begin
      bus(1, `USF_OFS_CONFIG, s << 6);
      rxc(P2);
      chk("fwd special", {1'b1, P2}, fwd);
      bus(0, `USF_OFS_IRQ_STATUS, 0);
      chk("special", s << 1, q & 2);
      bus(1, `USF_OFS_IRQ_CLEAR, 32'hFFF);
    end
    $display("receive side done");
    for (m = 0; m < 4; m++) begin
      bus(1, `USF_OFS_CONFIG, 1 | m << 1);
      rx_fill_high <= 1'b1;
      snd(P1, P2);
      rx_fill_high <= 1'b0;
      chk("remote paused", m != 0, paused);
      rx_fill_low <= 1'b1;
      snd(R1, R2);
      rx_fill_low <= 1'b0;
      chk("remote running", 0, paused);
    end
    $display("send side done");
    // Second reset in mid-run must wipe what was programmed
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, `USF_OFS_CONFIG, 0);
    chk("cfg after reset", 0, q);
    bus(0, `USF_OFS_PAUSE2, 0);
    chk("char after reset", 0, q);
    chk("outputs after reset", 0, tx_hold | irq | send_req);
    $display("mid-run reset done");
    print_verdict;
  end
endmodule
